// file: inc/pwt_pkg.sv
package pwt_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] RATE_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h00C;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CLK_SEL_BIT = 7;
  localparam int WAVE_SEL_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int FEATURE_EN_BIT = 2;
  localparam int IRQ_EN_BIT = 1;
  localparam int FLAG_BIT = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [0:0] MASK_RESET = 1'h0;
  // ---------------------------------------------------------------
  // autonomous clock: one enable pulse per this many bus cycles
  // ---------------------------------------------------------------
  localparam int AUTO_CLK_NS = 1000;
  localparam int PCLK_NS = 50;
  localparam logic [7:0] AUTO_DIV_CYCLES = 8'((AUTO_CLK_NS + PCLK_NS - 1) / PCLK_NS);
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clk_sel;
    logic wave_sel;
    logic ext_en;
    logic feature_en;
    logic irq_en;
    logic flag;
  } pwt_ctrl_t;
  typedef enum logic [0:0] {PWT_IDLE, PWT_RUN} pwt_state_t;
endpackage : pwt_pkg

// file: hdl/pwt_tick_div.sv
`timescale 1ns/10ps
module pwt_tick_div
  import pwt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  // ---------------------------------------------------------------
  // autonomous clock enable divider
  // ---------------------------------------------------------------
  always_comb
  begin
    if (cnt == AUTO_DIV_CYCLES - 8'h01)
      next_cnt = 8'h00;
    else
      next_cnt = cnt + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 8'h00;
    else
      cnt <= next_cnt;
  end
  assign tick = (cnt == AUTO_DIV_CYCLES - 8'h01);
endmodule : pwt_tick_div

// file: hdl/pwt_timer.sv
`timescale 1ns/10ps
// Operation
// R1: bit 7 picks autonomous or bus clock
// R2: clock select writable only while disabled
// R3: pulse mode: half-minimum-period pulse each period
// R4: clock mode: toggle pin each period
// R5: bit 4 selects pulse or clock mode
// R6: bit 3 gates waveform, needs feature enable
// R7: bit 2 enables and starts the timer
// R8: timer restarts after every timeout
// R9: flag bit 0 set on each timeout
// R10: flag cleared only by writing one
// R11: irq request while flag and enable set
module pwt_timer
  import pwt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timeout_irq,
  output logic irq,
  output logic periodic_output_pin
);
  import pwt_pkg::*;

  pwt_ctrl_t ctrl;
  pwt_ctrl_t next_ctrl;
  logic [15:0] period_rate_setting;
  logic [15:0] next_rate;
  logic [0:0] irq_status;
  logic [0:0] next_irq_status;
  logic [0:0] irq_mask;
  logic [0:0] next_irq_mask;
  logic [31:0] next_prdata;
  pwt_state_t state;
  pwt_state_t next_state;
  logic [16:0] cnt;
  logic [16:0] next_cnt;
  logic [15:0] pulse_cnt;
  logic [15:0] next_pulse_cnt;
  logic wave_clk;
  logic next_wave_clk;
  logic pin;
  logic next_pin;
  logic auto_tick;
  logic tick;
  logic timeout;
  logic wr;
  logic rd;
  logic rd_setup;
  logic [16:0] period_last;
  logic [15:0] pulse_len;

  // ---------------------------------------------------------------
  // clock source
  // ---------------------------------------------------------------
  pwt_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(auto_tick)
  );
  assign tick = ctrl.clk_sel ? 1'b1 : auto_tick; // [R1]

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == CTRL_OFFSET || paddr == RATE_OFFSET
    || paddr == IRQ_STATUS_OFFSET || paddr == IRQ_MASK_OFFSET);

  // period: 2 * (rate + 1) source ticks, so the minimum period is one tick pair
  assign period_last = {period_rate_setting, 1'b1};
  assign pulse_len = 16'h0001;
  assign timeout = (state == PWT_RUN) && ctrl.feature_en && tick && (cnt == period_last);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_rate = period_rate_setting;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_prdata = prdata;
    if (wr && paddr == CTRL_OFFSET)
    begin
      if (!ctrl.feature_en && !pwdata[FEATURE_EN_BIT])
        next_ctrl.clk_sel = pwdata[CLK_SEL_BIT]; // [R2]
      next_ctrl.wave_sel = pwdata[WAVE_SEL_BIT]; // [R5]
      next_ctrl.ext_en = pwdata[EXT_EN_BIT]; // [R6]
      next_ctrl.feature_en = pwdata[FEATURE_EN_BIT]; // [R7]
      next_ctrl.irq_en = pwdata[IRQ_EN_BIT]; // [R11]
      if (pwdata[FLAG_BIT])
        next_ctrl.flag = 1'b0; // [R10]
    end
    if (timeout)
      next_ctrl.flag = 1'b1; // [R9]
    if (wr && paddr == RATE_OFFSET)
      next_rate = pwdata[15:0];
    if (wr && paddr == IRQ_MASK_OFFSET)
      next_irq_mask = pwdata[0:0];
    // clear only what the read reported, so a set after the setup phase is kept
    if (rd && paddr == IRQ_STATUS_OFFSET)
      next_irq_status = irq_status & ~prdata[0:0];
    if (timeout)
      next_irq_status = 1'b1;
    // read data loads in the setup phase and stands through the access phase
    if (rd_setup)
    begin
      case (paddr)
        CTRL_OFFSET: next_prdata = {24'h000000, ctrl.clk_sel, 2'b00, ctrl.wave_sel,
          ctrl.ext_en, ctrl.feature_en, ctrl.irq_en, ctrl.flag};
        RATE_OFFSET: next_prdata = {16'h0000, period_rate_setting};
        IRQ_STATUS_OFFSET: next_prdata = {31'h00000000, irq_status};
        IRQ_MASK_OFFSET: next_prdata = {31'h00000000, irq_mask};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= pwt_ctrl_t'(6'h00);
      period_rate_setting <= RATE_RESET;
      irq_mask <= MASK_RESET;
      irq_status <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ctrl <= next_ctrl;
      period_rate_setting <= next_rate;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // period counter
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_wave_clk = wave_clk;
    next_pulse_cnt = pulse_cnt;
    case (state)
      PWT_IDLE:
      begin
        next_cnt = 17'h00000;
        next_wave_clk = 1'b0;
        next_pulse_cnt = 16'h0000;
        if (ctrl.feature_en)
          next_state = PWT_RUN; // [R7]
      end
      PWT_RUN:
      begin
        if (!ctrl.feature_en)
          next_state = PWT_IDLE; // [R7]
        else if (tick)
        begin
          if (pulse_cnt != 16'h0000)
            next_pulse_cnt = pulse_cnt - 16'h0001;
          if (timeout)
          begin
            next_cnt = 17'h00000; // [R8]
            next_wave_clk = !wave_clk; // [R4]
            next_pulse_cnt = pulse_len; // [R3]
          end
          else
            next_cnt = cnt + 17'h00001;
        end
      end
      default: next_state = PWT_IDLE;
    endcase
    if (ctrl.ext_en && ctrl.feature_en) // [R6]
      next_pin = ctrl.wave_sel ? next_wave_clk : (next_pulse_cnt != 16'h0000); // [R5]
    else
      next_pin = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= PWT_IDLE;
      cnt <= 17'h00000;
      wave_clk <= 1'b0;
      pulse_cnt <= 16'h0000;
      pin <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wave_clk <= next_wave_clk;
      pulse_cnt <= next_pulse_cnt;
      pin <= next_pin;
    end
  end

  assign periodic_output_pin = pin;
  assign timeout_irq = ctrl.flag && ctrl.irq_en; // [R11]
  assign irq = irq_status[0] && irq_mask[0];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_clk_sel_hold;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.feature_en || (wr && paddr == CTRL_OFFSET && pwdata[FEATURE_EN_BIT]))
    |=> $stable(ctrl.clk_sel) || !$past(ctrl.feature_en) && !$past(pwdata[FEATURE_EN_BIT]);
  endproperty
  a_clk_sel_hold: assert property (p_clk_sel_hold) else $error("clock select changed"); // [R2]

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    timeout |=> ctrl.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on timeout"); // [R9]

  property p_flag_clear_only_w1;
    @(posedge pclk) disable iff (!presetn)
    ctrl.flag && !(wr && paddr == CTRL_OFFSET && pwdata[FLAG_BIT]) |=> ctrl.flag;
  endproperty
  a_flag_clear_only_w1: assert property (p_flag_clear_only_w1) else $error("flag lost"); // [R10]

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == CTRL_OFFSET && pwdata[FLAG_BIT] && !timeout |=> !ctrl.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [R10]

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    timeout_irq == (ctrl.flag && ctrl.irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq request wrong"); // [R11]

  property p_pin_gated;
    @(posedge pclk) disable iff (!presetn)
    !(ctrl.ext_en && ctrl.feature_en) |=> !periodic_output_pin;
  endproperty
  a_pin_gated: assert property (p_pin_gated) else $error("pin driven while gated"); // [R6]

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    timeout && ctrl.ext_en && ctrl.feature_en && !ctrl.wave_sel ##1
    ctrl.ext_en && ctrl.feature_en && !ctrl.wave_sel |-> periodic_output_pin;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse at period end"); // [R3]

  property p_clock_toggle;
    @(posedge pclk) disable iff (!presetn)
    timeout && ctrl.feature_en |=> wave_clk != $past(wave_clk);
  endproperty
  a_clock_toggle: assert property (p_clock_toggle) else $error("clock not toggled"); // [R4]

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    timeout && ctrl.feature_en |=> cnt == 17'h00000;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted"); // [R8]

  property p_disable;
    @(posedge pclk) disable iff (!presetn)
    !ctrl.feature_en |=> state == PWT_IDLE;
  endproperty
  a_disable: assert property (p_disable) else $error("timer runs while disabled"); // [R7]

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    state == PWT_IDLE && ctrl.feature_en |=> state == PWT_RUN;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start"); // [R7]

  property p_irq_raise;
    @(posedge pclk) disable iff (!presetn)
    timeout && ctrl.irq_en && !wr |=> timeout_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq request not raised"); // [R11]

  property p_bus_count;
    @(posedge pclk) disable iff (!presetn)
    state == PWT_RUN && ctrl.feature_en && ctrl.clk_sel && !timeout
    |=> cnt == $past(cnt) + 17'h00001;
  endproperty
  a_bus_count: assert property (p_bus_count) else $error("count missed a tick"); // [R1]

  property p_auto_wait;
    @(posedge pclk) disable iff (!presetn)
    state == PWT_RUN && !ctrl.clk_sel && !auto_tick |=> $stable(cnt);
  endproperty
  a_auto_wait: assert property (p_auto_wait) else $error("count moved"); // [R1]

  property p_clock_pin;
    @(posedge pclk) disable iff (!presetn)
    ctrl.ext_en && ctrl.feature_en && ctrl.wave_sel |=> periodic_output_pin == wave_clk;
  endproperty
  a_clock_pin: assert property (p_clock_pin) else $error("pin not the clock"); // [R5]

  property p_pulse_end;
    @(posedge pclk) disable iff (!presetn)
    periodic_output_pin && ctrl.ext_en && ctrl.feature_en && !ctrl.wave_sel && tick && !timeout
    |=> !periodic_output_pin;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long"); // [R3]
endmodule : pwt_timer

// file: testbench/pwt_timer_bench.sv
`timescale 1ns/10ps
module pwt_timer_bench;
  import pwt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic timeout_irq, irq, periodic_output_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  int n_mismatch, n_checks;
  pwt_timer pwt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timeout_irq(timeout_irq), .irq(irq),
    .periodic_output_pin(periodic_output_pin));
  // ---------------------------------------------------------------
  // clock and helpers
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // apb transfer: setup, access until pready, answer taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the access edge settle before callers look at outputs
    @(negedge pclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask : rdchk
  // high and low time of one full pin period, in bus cycles
  task automatic meas(output int hi, output int lo);
    while (periodic_output_pin !== 1'b0) @(negedge pclk);
    while (periodic_output_pin !== 1'b1) @(negedge pclk);
    hi = 0;
    lo = 0;
    while (periodic_output_pin === 1'b1)
    begin
      hi++;
      @(negedge pclk);
    end
    while (periodic_output_pin === 1'b0)
    begin
      lo++;
      @(negedge pclk);
    end
  endtask : meas
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] sel, wave, rate;
    int tick, per, hi, lo;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    seed = 32'h00003F99;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CTRL_OFFSET, 32'hFF, 32'h00);
    rdchk(RATE_OFFSET, 32'hFFFF, 32'h0);
    rdchk(IRQ_MASK_OFFSET, 32'h1, 32'h0);
    rdchk(12'h010, 32'hFFFFFFFF, 32'h0);
    cmp(err, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h84);
    rdchk(CTRL_OFFSET, 32'hFE, 32'h04);
    apb(1'b1, CTRL_OFFSET, 32'h80);
    rdchk(CTRL_OFFSET, 32'hFE, 32'h00);
    apb(1'b1, CTRL_OFFSET, 32'h80);
    rdchk(CTRL_OFFSET, 32'hFE, 32'h80);
    apb(1'b1, CTRL_OFFSET, 32'h84);
    apb(1'b1, CTRL_OFFSET, 32'h04);
    rdchk(CTRL_OFFSET, 32'hFE, 32'h84);
    apb(1'b1, CTRL_OFFSET, 32'h00);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      seed = xorshift(seed);
      rate = (k == 0) ? 32'h0 : {29'h0, seed[2:0]};
      sel = (k == 5) ? 32'h0 : 32'h80;
      wave = {27'h0, seed[8], 4'h0};
      tick = (sel != 0) ? 1 : int'(AUTO_DIV_CYCLES);
      per = 2 * (int'(rate) + 1) * tick;
      apb(1'b1, CTRL_OFFSET, sel);
      apb(1'b1, RATE_OFFSET, rate);
      rdchk(RATE_OFFSET, 32'hFFFF, rate);
      apb(1'b1, CTRL_OFFSET, sel | wave | 32'h0F);
      meas(hi, lo);
      if (wave != 0)
      begin
        cmp(hi, per);
        cmp(lo, per);
      end
      else
      begin
        cmp(hi, tick);
        cmp(hi + lo, per);
      end
      cmp(timeout_irq, 1'b1);
      apb(1'b1, CTRL_OFFSET, sel | 32'h2);
      rdchk(CTRL_OFFSET, 32'hFF, sel | 32'h3);
      cmp(irq, 1'b1);
      rdchk(IRQ_STATUS_OFFSET, 32'h1, 32'h1);
      cmp(irq, 1'b0);
      apb(1'b1, CTRL_OFFSET, sel);
      cmp(timeout_irq, 1'b0);
      apb(1'b1, CTRL_OFFSET, sel | 32'h1);
      rdchk(CTRL_OFFSET, 32'hFF, sel);
    end
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h80);
    apb(1'b1, CTRL_OFFSET, 32'h96);
    repeat (20)
    begin
      @(negedge pclk);
      cmp(periodic_output_pin, 1'b0);
      cmp(irq, 1'b0);
    end
    cmp(timeout_irq, 1'b1);
    summarize();
  end
endmodule : pwt_timer_bench
